/* File: core/mtax_consts.vh */
// Constants for the timer A / timer X block: register offsets, field positions,
// reset values and mode codes. Definitions only.
`ifndef MTAX_CONSTS_VH
`define MTAX_CONSTS_VH

// Register offsets (8-bit address, 8-bit data)
`define MTAX_OFS_TA_LOW    8'h00
`define MTAX_OFS_TA_HIGH   8'h01
`define MTAX_OFS_TA_MODE   8'h02
`define MTAX_OFS_PRE_X     8'h03
`define MTAX_OFS_TX_CNT    8'h04
`define MTAX_OFS_TX_MODE   8'h05
`define MTAX_OFS_IRQ       8'h06

// Timer A mode register fields
`define MTAX_TA_MODE_LSB   0
`define MTAX_TA_EDGE_BIT   2
`define MTAX_TA_STOP_BIT   3
`define MTAX_TA_SRC_LSB    4

// Timer X mode register fields
`define MTAX_TX_MODE_LSB   0
`define MTAX_TX_EDGE_BIT   2
`define MTAX_TX_STOP_BIT   3
`define MTAX_TX_WCTL_BIT   4
`define MTAX_TX_COMP_BIT   5
`define MTAX_TX_SRC_LSB    6

// Request flag positions
`define MTAX_IRQ_TA_UF     0
`define MTAX_IRQ_CAP_A     1
`define MTAX_IRQ_TX_UF     2
`define MTAX_IRQ_PIN_X     3

// Mode codes, timer A
`define MTAX_TA_TIMER      2'h0
`define MTAX_TA_PERIOD     2'h1
`define MTAX_TA_EVENT      2'h2
`define MTAX_TA_PULSE_HL   2'h3

// Mode codes, timer X
`define MTAX_TX_TIMER      2'h0
`define MTAX_TX_PULSE_OUT  2'h1
`define MTAX_TX_EVENT      2'h2
`define MTAX_TX_PW_MEAS    2'h3

// Reset values
`define MTAX_RST_TA        16'hffff
`define MTAX_RST_X         8'hff
`define MTAX_RST_MODE      8'h00

`endif

/* File: core/mtax_timers.v */
// Timer A (16-bit) and timer X (8-bit with 8-bit prescaler) with reload latches.
// Assumes a single 100 MHz clock, a plain register port from the CPU, and
// asynchronous pin inputs that are synchronised here.
//
// Summary of operation
// RULE1: Timer A is 16-bit down counter with latch
// RULE2: Zero then next count underflows and reloads
// RULE3: Reload value n divides source by n+1
// RULE4: Period mode: pin edge requests and reloads
// RULE5: Captured value held until timer A read
// RULE6: Event mode counts capture pin edges
// RULE7: Pulse HL mode requests on both edges
// RULE8: Edge bit 0 falling, 1 rising
// RULE9: Timer A stop bit halts counting
// RULE10: Timer A underflow sets its request
// RULE11: Timer X counts prescaler underflows, both reload
// RULE12: Write control picks latch only or both
// RULE13: Division is (n+1) times (m+1)
// RULE14: Pulse output toggles on timer X underflow
// RULE15: Edge bit 0 starts high, 1 low
// RULE16: Complementary pin drives inverted pulse output
// RULE17: Timer X event mode counts pin edges
// RULE18: Pulse width mode gates count by pin level
// RULE19: Timer X stop bit halts counting
// RULE20: Timer X underflow sets its request
// RULE21: Pin X request on falling or rising edge
// RULE22: Software writes low first, reads high first
// RULE23: Two-bit mode field selects four modes
`include "mtax_consts.vh"

module mtax_timers #(
  parameter AW = 8,
  parameter DW = 8
) (
  input  wire          clock,
  input  wire          nrst,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  input  wire          wr,
  input  wire          rd,
  output reg  [DW-1:0] rdata,
  input  wire          capture_pin_a,
  input  wire          io_pin_x_in,
  output wire          io_pin_x_out,
  output wire          io_pin_x_oe,
  output wire          inverted_out_x,
  output wire          inverted_out_x_oe,
  output wire          irq_timer_a,
  output wire          irq_capture_a,
  output wire          irq_timer_x,
  output wire          irq_pin_x
);

  ////////////////////////////////////////////////////////////////////////////
  // Count source selection from a free-running divider

  reg  [7:0] div_r;
  reg  [7:0] div_prev_r;

  function src_tick;
    input [1:0] sel;
    input [7:0] cur;
    input [7:0] prev;
    begin
      case (sel)
        2'h0:    src_tick = 1'b1;
        2'h1:    src_tick = cur[0] & ~prev[0];
        2'h2:    src_tick = cur[2] & ~prev[2];
        default: src_tick = cur[3] & ~prev[3];
      endcase
    end
  endfunction

  always @(posedge clock) begin
    if (!nrst) begin
      div_r      <= 8'h00;
      div_prev_r <= 8'h00;
    end else begin
      div_r      <= div_r + 8'h01;
      div_prev_r <= div_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  reg  [2:0] cap_sync_r;
  reg  [2:0] pinx_sync_r;

  always @(posedge clock) begin
    if (!nrst) begin
      cap_sync_r  <= 3'h7;
      pinx_sync_r <= 3'h7;
    end else begin
      cap_sync_r  <= {cap_sync_r[1:0], capture_pin_a};
      pinx_sync_r <= {pinx_sync_r[1:0], io_pin_x_in};
    end
  end

  wire cap_rise  = cap_sync_r[1] & ~cap_sync_r[2];
  wire cap_fall  = ~cap_sync_r[1] & cap_sync_r[2];
  wire pinx_rise = pinx_sync_r[1] & ~pinx_sync_r[2];
  wire pinx_fall = ~pinx_sync_r[1] & pinx_sync_r[2];
  wire pinx_lvl  = pinx_sync_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers

  reg  [7:0] ta_mode_r;
  reg  [7:0] tx_mode_r;

  wire [1:0] ta_mode = ta_mode_r[`MTAX_TA_MODE_LSB+1:`MTAX_TA_MODE_LSB];  // [RULE23]
  wire       ta_edge = ta_mode_r[`MTAX_TA_EDGE_BIT];
  wire       ta_stop = ta_mode_r[`MTAX_TA_STOP_BIT];
  wire [1:0] ta_src  = ta_mode_r[`MTAX_TA_SRC_LSB+1:`MTAX_TA_SRC_LSB];
  wire [1:0] tx_mode = tx_mode_r[`MTAX_TX_MODE_LSB+1:`MTAX_TX_MODE_LSB];  // [RULE23]
  wire       tx_edge = tx_mode_r[`MTAX_TX_EDGE_BIT];
  wire       tx_stop = tx_mode_r[`MTAX_TX_STOP_BIT];
  wire       tx_wctl = tx_mode_r[`MTAX_TX_WCTL_BIT];
  wire       tx_comp = tx_mode_r[`MTAX_TX_COMP_BIT];
  wire [1:0] tx_src  = tx_mode_r[`MTAX_TX_SRC_LSB+1:`MTAX_TX_SRC_LSB];

  wire wr_ta_lo  = wr && (addr == `MTAX_OFS_TA_LOW);
  wire wr_ta_hi  = wr && (addr == `MTAX_OFS_TA_HIGH);
  wire wr_ta_md  = wr && (addr == `MTAX_OFS_TA_MODE);
  wire wr_pre    = wr && (addr == `MTAX_OFS_PRE_X);
  wire wr_tx     = wr && (addr == `MTAX_OFS_TX_CNT);
  wire wr_tx_md  = wr && (addr == `MTAX_OFS_TX_MODE);
  wire wr_irq    = wr && (addr == `MTAX_OFS_IRQ);
  wire rd_ta_hi  = rd && (addr == `MTAX_OFS_TA_HIGH);
  wire rd_ta_lo  = rd && (addr == `MTAX_OFS_TA_LOW);

  always @(posedge clock) begin
    if (!nrst) begin
      ta_mode_r <= `MTAX_RST_MODE;
      tx_mode_r <= `MTAX_RST_MODE;
    end else begin
      if (wr_ta_md)
        ta_mode_r <= wdata;
      if (wr_tx_md)
        tx_mode_r <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer A

  reg  [15:0] ta_cnt_r;
  reg  [15:0] ta_latch_r;
  reg  [7:0]  ta_wbuf_r;
  reg  [7:0]  ta_rbuf_r;
  reg  [15:0] ta_cap_r;
  reg         ta_hold_r;

  wire ta_measure = (ta_mode == `MTAX_TA_PERIOD) || (ta_mode == `MTAX_TA_PULSE_HL);
  wire ta_sel_edge = ta_edge ? cap_rise : cap_fall;                                    // [RULE8]
  wire ta_trig = (ta_mode == `MTAX_TA_PULSE_HL) ? (cap_rise | cap_fall) :              // [RULE7]
                 (ta_mode == `MTAX_TA_PERIOD)   ? ta_sel_edge : 1'b0;                   // [RULE4]
  wire ta_tick = (ta_mode == `MTAX_TA_EVENT) ? ta_sel_edge : src_tick(ta_src, div_r, div_prev_r); // [RULE6]
  wire ta_run  = ~ta_stop;                                                              // [RULE9]
  wire ta_uf   = ta_run && ta_tick && !ta_trig && (ta_cnt_r == 16'h0000);               // [RULE2]
  wire cap_req = ta_mode == `MTAX_TA_PULSE_HL ? (cap_rise | cap_fall) : ta_sel_edge;    // [RULE8]
  wire [15:0] ta_view = ta_measure ? ta_cap_r : ta_cnt_r;

  always @(posedge clock) begin
    if (!nrst) begin
      ta_cnt_r   <= `MTAX_RST_TA;
      ta_latch_r <= `MTAX_RST_TA;
      ta_wbuf_r  <= 8'h00;
      ta_rbuf_r  <= 8'h00;
      ta_cap_r   <= 16'h0000;
      ta_hold_r  <= 1'b0;
    end else begin
      if (wr_ta_lo)
        ta_wbuf_r <= wdata;                                       // [RULE22]
      if (rd_ta_hi)
        ta_rbuf_r <= ta_view[7:0];                                // [RULE22]
      if (wr_ta_hi) begin
        ta_latch_r <= {wdata, ta_wbuf_r};                         // [RULE1]
        ta_cnt_r   <= {wdata, ta_wbuf_r};
      end else if (ta_run && ta_trig) begin
        ta_cnt_r <= ta_latch_r;                                   // [RULE4]
      end else if (ta_run && ta_tick) begin
        if (ta_cnt_r == 16'h0000)
          ta_cnt_r <= ta_latch_r;                                 // [RULE2] [RULE3]
        else
          ta_cnt_r <= ta_cnt_r - 16'h0001;                        // [RULE1]
      end
      if (ta_run && ta_trig && !ta_hold_r) begin
        ta_cap_r  <= ta_cnt_r;                                    // [RULE5]
        ta_hold_r <= 1'b1;
      end else if (rd_ta_lo || !ta_measure) begin
        ta_hold_r <= 1'b0;                                        // [RULE5]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer X and prescaler X

  reg  [7:0] pre_cnt_r;
  reg  [7:0] pre_latch_r;
  reg  [7:0] tx_cnt_r;
  reg  [7:0] tx_latch_r;
  reg        pulse_r;

  wire tx_sel_edge = tx_edge ? pinx_rise : pinx_fall;                                  // [RULE21]
  wire tx_gate     = tx_edge ? ~pinx_lvl : pinx_lvl;                                    // [RULE18]
  wire tx_src_tick = src_tick(tx_src, div_r, div_prev_r);
  wire pre_tick    = (tx_mode == `MTAX_TX_EVENT)   ? tx_sel_edge :                     // [RULE17]
                     (tx_mode == `MTAX_TX_PW_MEAS) ? (tx_src_tick & tx_gate) :          // [RULE18]
                     tx_src_tick;
  wire tx_run  = ~tx_stop;                                                              // [RULE19]
  wire pre_uf  = tx_run && pre_tick && (pre_cnt_r == 8'h00);                            // [RULE13]
  wire tx_uf   = pre_uf && (tx_cnt_r == 8'h00);                                         // [RULE11]
  wire tx_pulse_mode = (tx_mode == `MTAX_TX_PULSE_OUT);

  always @(posedge clock) begin
    if (!nrst) begin
      pre_cnt_r   <= `MTAX_RST_X;
      pre_latch_r <= `MTAX_RST_X;
      tx_cnt_r    <= `MTAX_RST_X;
      tx_latch_r  <= `MTAX_RST_X;
      pulse_r     <= 1'b1;
    end else begin
      if (wr_pre) begin
        pre_latch_r <= wdata;                                     // [RULE12]
        if (!tx_wctl)
          pre_cnt_r <= wdata;
      end else if (tx_run && pre_tick) begin
        if (pre_cnt_r == 8'h00)
          pre_cnt_r <= pre_latch_r;                               // [RULE11]
        else
          pre_cnt_r <= pre_cnt_r - 8'h01;
      end
      if (wr_tx) begin
        tx_latch_r <= wdata;                                      // [RULE12]
        if (!tx_wctl)
          tx_cnt_r <= wdata;
      end else if (pre_uf) begin
        if (tx_cnt_r == 8'h00)
          tx_cnt_r <= tx_latch_r;                                 // [RULE11] [RULE13]
        else
          tx_cnt_r <= tx_cnt_r - 8'h01;
      end
      if (!tx_pulse_mode || wr_tx_md)
        pulse_r <= ~(wr_tx_md ? wdata[`MTAX_TX_EDGE_BIT] : tx_edge); // [RULE15]
      else if (tx_uf)
        pulse_r <= ~pulse_r;                                      // [RULE14]
    end
  end

  assign io_pin_x_out      = pulse_r;
  assign io_pin_x_oe       = tx_pulse_mode;
  assign inverted_out_x    = ~pulse_r;                            // [RULE16]
  assign inverted_out_x_oe = tx_comp;                             // [RULE16]

  ////////////////////////////////////////////////////////////////////////////
  // Request flags: set wins over write-one-to-clear

  reg  [3:0] irq_r;
  wire [3:0] irq_set;

  assign irq_set[`MTAX_IRQ_TA_UF] = ta_uf;                        // [RULE10]
  assign irq_set[`MTAX_IRQ_CAP_A] = cap_req;                      // [RULE4] [RULE7] [RULE8]
  assign irq_set[`MTAX_IRQ_TX_UF] = tx_uf;                        // [RULE20]
  assign irq_set[`MTAX_IRQ_PIN_X] = tx_sel_edge;                  // [RULE21]

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_irq
      always @(posedge clock) begin
        if (!nrst)
          irq_r[gi] <= 1'b0;
        else if (irq_set[gi])
          irq_r[gi] <= 1'b1;
        else if (wr_irq && wdata[gi])
          irq_r[gi] <= 1'b0;
      end
    end
  endgenerate

  assign irq_timer_a   = irq_r[`MTAX_IRQ_TA_UF];
  assign irq_capture_a = irq_r[`MTAX_IRQ_CAP_A];
  assign irq_timer_x   = irq_r[`MTAX_IRQ_TX_UF];
  assign irq_pin_x     = irq_r[`MTAX_IRQ_PIN_X];

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe

  always @(posedge clock) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `MTAX_OFS_TA_LOW:  rdata <= ta_rbuf_r;                    // [RULE22]
        `MTAX_OFS_TA_HIGH: rdata <= ta_view[15:8];                // [RULE5]
        `MTAX_OFS_TA_MODE: rdata <= ta_mode_r;
        `MTAX_OFS_PRE_X:   rdata <= pre_cnt_r;                    // [RULE12]
        `MTAX_OFS_TX_CNT:  rdata <= tx_cnt_r;                     // [RULE12]
        `MTAX_OFS_TX_MODE: rdata <= tx_mode_r;
        `MTAX_OFS_IRQ:     rdata <= {4'h0, irq_r};
        default:           rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // mtax_timers

/* File: tb/mtax_pins.sv */
// Pin source model: drives the two timer pin inputs.
// Assumes the bench commands levels; pins idle high.
module mtax_pins (
  input  wire  clock,
  output logic capture_pin_a,
  output logic pin_x
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    capture_pin_a = 1'b1;
    pin_x         = 1'b1;
  end
  // New levels just after a rising edge
  task drive(input logic a, input logic x);
    @(posedge clock);
    capture_pin_a <= a;
    pin_x         <= x;
  endtask
endmodule // mtax_pins

/* File: tb/mtax_chk_assertions.sv */
// Port checker for the timer A / timer X block.
// Assumes one clock domain and pins held high through reset.
`include "mtax_consts.vh"
module mtax_chk (
  input wire       clock,
  input wire       nrst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire       capture_pin_a,
  input wire       io_pin_x_in,
  input wire       io_pin_x_out,
  input wire       io_pin_x_oe,
  input wire       inverted_out_x,
  input wire       inverted_out_x_oe,
  input wire       irq_timer_a,
  input wire       irq_capture_a,
  input wire       irq_timer_x,
  input wire       irq_pin_x
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       pa_r;
  logic       px_r;
  logic [3:0] age_a_r;
  logic [3:0] age_x_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Cycles since each pin last moved
  always @(posedge clock) begin
    pa_r    <= capture_pin_a;
    px_r    <= io_pin_x_in;
    age_a_r <= (!nrst || capture_pin_a != pa_r) ? 4'h0 : age_a_r + {3'h0, age_a_r != 4'hf};
    age_x_r <= (!nrst || io_pin_x_in != px_r) ? 4'h0 : age_x_r + {3'h0, age_x_r != 4'hf};
  end
  ////////////////////////////////////////
  property p_rd_idle; !$past(rd) |-> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data without read");
  property p_inv; inverted_out_x == !io_pin_x_out; endproperty
  a_inv: assert property (p_inv)
    else $error("complementary output not inverse");
  property p_ta_hold;
    irq_timer_a && !(wr && addr == `MTAX_OFS_IRQ && wdata[0]) |=> irq_timer_a;
  endproperty
  a_ta_hold: assert property (p_ta_hold)
    else $error("timer A request lost");
  property p_tx_hold;
    irq_timer_x && !(wr && addr == `MTAX_OFS_IRQ && wdata[2]) |=> irq_timer_x;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("timer X request lost");
  property p_cap_src; $rose(irq_capture_a) |-> age_a_r < 4'h6; endproperty
  a_cap_src: assert property (p_cap_src)
    else $error("capture request without pin edge");
  property p_pin_src; $rose(irq_pin_x) |-> age_x_r < 4'h6; endproperty
  a_pin_src: assert property (p_pin_src)
    else $error("pin X request without pin edge");
  property p_tog;
    $changed(io_pin_x_out) && io_pin_x_oe && $past(io_pin_x_oe) && !$past(wr) |-> irq_timer_x;
  endproperty
  a_tog: assert property (p_tog)
    else $error("pulse output moved without underflow");
  property p_rst;
    $rose(nrst) |-> !irq_timer_a && !irq_timer_x && io_pin_x_out && !io_pin_x_oe && !inverted_out_x_oe;
  endproperty
  a_rst: assert property (p_rst)
    else $error("bad state after reset");
  property p_mode_hold; !$past(wr) |-> $stable(io_pin_x_oe) && $stable(inverted_out_x_oe); endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("output enable moved without write");
endmodule // mtax_chk

bind mtax_timers mtax_chk u_mtax_chk (.clock, .nrst, .addr, .wdata, .wr, .rd, .rdata, .capture_pin_a,
  .io_pin_x_in, .io_pin_x_out, .io_pin_x_oe, .inverted_out_x, .inverted_out_x_oe, .irq_timer_a,
  .irq_capture_a, .irq_timer_x, .irq_pin_x);

/* File: tb/mtax_timers_tb_top.sv */
// Testbench for the timer A / timer X block.
// Assumes the pin source model and the bound port checker.
`include "mtax_consts.vh"
module mtax_timers_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] TAM = `MTAX_OFS_TA_MODE;
  localparam logic [7:0] TXM = `MTAX_OFS_TX_MODE;
  localparam logic [7:0] TXC = `MTAX_OFS_TX_CNT;
  localparam logic [7:0] IRQ = `MTAX_OFS_IRQ;
  logic       clock = 1'b0;
  logic       nrst  = 1'b0;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] hi, lo;
  wire  [7:0] rdata;
  wire  [3:0] irq;
  wire        capture_pin_a, pin_x, io_pin_x_in, io_pin_x_out, io_pin_x_oe;
  wire        inverted_out_x, inverted_out_x_oe;
  int         errors   = 0;
  int         compares = 0;
  assign io_pin_x_in = io_pin_x_oe ? io_pin_x_out : pin_x;
  mtax_pins u_mtax_pins (.clock, .capture_pin_a, .pin_x);
  mtax_timers u_mtax_timers (.clock, .nrst, .addr, .wdata, .wr, .rd, .rdata, .capture_pin_a,
    .io_pin_x_in, .io_pin_x_out, .io_pin_x_oe, .inverted_out_x, .inverted_out_x_oe,
    .irq_timer_a(irq[0]), .irq_capture_a(irq[1]), .irq_timer_x(irq[2]), .irq_pin_x(irq[3]));
  initial forever #5 clock = ~clock;
  ////////////////////////////////////////
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Cycles between two requests on one flag
  task per(input int b, input int e);
    int n;
    wrt(IRQ, 8'h0f);
    n = 0;
    do begin @(posedge clock); #1; n++; end while (irq[b] !== 1'b1 && n < 400);
    wrt(IRQ, 8'h01 << b);
    n = 2;
    do begin @(posedge clock); #1; n++; end while (irq[b] !== 1'b1 && n < 400);
    chk("period", e, n);
  endtask
  task pin(input logic a, input logic x, input int b, input logic e);
    wrt(IRQ, 8'h0f);
    u_mtax_pins.drive(a, x);
    repeat (6) @(posedge clock);
    #1;
    chk("pin_irq", e, irq[b]);
  endtask
  task s_timers;
    wrt(TAM, 8'h08);
    wrt(`MTAX_OFS_TA_LOW, 8'h02);
    wrt(`MTAX_OFS_TA_HIGH, 8'h00);
    wrt(TAM, 8'h00);
    per(0, 3);
    wrt(TAM, 8'h10);
    per(0, 6);
    wrt(TXM, 8'h08);
    wrt(`MTAX_OFS_PRE_X, 8'h01);
    wrt(TXC, 8'h02);
    wrt(TXM, 8'h00);
    per(2, 6);
  endtask
  task s_pulse;
    int  n;
    logic p;
    wrt(TXM, 8'h21);
    chk("pout", 1, io_pin_x_out);
    chk("oe", 3, {io_pin_x_oe, inverted_out_x_oe});
    n = 0;
    p = io_pin_x_out;
    do begin @(posedge clock); #1; n++; end while (io_pin_x_out === p && n < 99);
    n = 0;
    p = io_pin_x_out;
    do begin @(posedge clock); #1; n++; end while (io_pin_x_out === p && n < 99);
    chk("toggle", 6, n);
    wrt(TXM, 8'h25);
    chk("pout", 0, io_pin_x_out);
    chk("inv", 1, inverted_out_x);
  endtask
  task s_stop;
    wrt(TAM, 8'h08);
    wrt(TXM, 8'h08);
    repeat (8) @(posedge clock);
    wrt(IRQ, 8'h0f);
    repeat (30) @(posedge clock);
    #1;
    chk("stop_a", 0, irq[0]);
    chk("stop_x", 0, irq[2]);
    wrt(TXC, 8'h20);
    rdr(TXC, lo);
    chk("tx_both", 8'h20, lo);
    wrt(TXM, 8'h18);
    wrt(TXC, 8'h10);
    rdr(TXC, lo);
    chk("tx_latch", 8'h20, lo);
  endtask
  task s_event;
    wrt(`MTAX_OFS_TA_LOW, 8'h05);
    wrt(`MTAX_OFS_TA_HIGH, 8'h00);
    wrt(TAM, 8'h06);
    for (int i = 0; i < 3; i++) begin
      u_mtax_pins.drive(1'b0, 1'b1);
      repeat (5) @(posedge clock);
      u_mtax_pins.drive(1'b1, 1'b1);
      repeat (5) @(posedge clock);
    end
    wrt(TAM, 8'h0e);
    rdr(`MTAX_OFS_TA_HIGH, hi);
    rdr(`MTAX_OFS_TA_LOW, lo);
    chk("events", 16'h0002, {hi, lo});
  endtask
  task s_pins;
    wrt(TAM, 8'h09);
    pin(1'b0, 1'b1, 1, 1'b1);
    pin(1'b1, 1'b1, 1, 1'b0);
    wrt(TAM, 8'h0b);
    pin(1'b0, 1'b1, 1, 1'b1);
    pin(1'b1, 1'b1, 1, 1'b1);
    wrt(TXM, 8'h0c);
    pin(1'b1, 1'b0, 3, 1'b0);
    pin(1'b1, 1'b1, 3, 1'b1);
  endtask
  task final_report;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    #1;
    chk("irq_rst", 0, irq);
    chk("pout_rst", 1, io_pin_x_out);
    rdr(8'h07, lo);
    chk("unmapped", 0, lo);
    s_timers;
    s_pulse;
    s_stop;
    s_event;
    s_pins;
    final_report;
  end
endmodule // mtax_timers_tb_top
